// file: message_device_comm_regs.sv
// Purpose: Communication register bank of a message-based instrument
// Assumes: Bus strobes are synchronous to clock; one cycle per strobe edge
// Notes:   Terminations are held until the data strobe is withdrawn

module message_device_comm_regs #(
	parameter bit         SERVANT_ONLY     = 1'b1,
	parameter bit         SIGNAL_PRESENT   = 1'b1,
	parameter bit         MASTER_CAPABLE   = 1'b1,
	parameter bit         INTERRUPTER      = 1'b0,
	parameter bit         FAST_HANDSHAKE   = 1'b0,
	parameter bit         SHARED_MEMORY    = 1'b0,
	parameter bit         WIDE32           = 1'b0,
	parameter bit         WIDE64           = 1'b0,
	parameter bit         RETRY_PREFERRED  = 1'b1,
	parameter logic [3:0] DEV_DEP_BITS     = 4'hF,
	parameter logic [6:0] STATUS_DEV_BITS  = 7'h7F,
	parameter int         STRETCH_LIMIT    = msg_regs_pkg::STRETCH_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Backplane slave side
	input  wire logic        bus_sel,
	input  wire logic [5:0]  bus_addr,
	input  wire logic        bus_write,
	input  wire logic        bus_ds0,
	input  wire logic        bus_ds1,
	input  wire logic [15:0] bus_wdata,
	output logic      [15:0] bus_rdata,
	output logic             bus_ack,
	output logic             bus_retry,
	output logic             bus_error,
	// Internal logic side
	output logic      [15:0] signal_word,
	output logic             signal_pending,
	output logic             signal_strobe,
	input  wire logic        signal_consume,
	output logic      [15:0] data_in_word,
	output logic             data_in_strobe,
	input  wire logic [15:0] result_low,
	input  wire logic [15:0] result_high,
	input  wire logic        result_load,
	input  wire logic        write_accept_ready,
	input  wire logic        byte_out_ready,
	input  wire logic        byte_in_ready,
	input  wire logic        protocol_error_set,
	input  wire logic        protocol_error_reported
);

	typedef struct packed {
		msg_regs_pkg::cycle_state_t state;
		msg_regs_pkg::term_t        term;
		logic [31:0]                stretch;
		logic [15:0]                rdata;
		logic                       ack;
		logic                       retry;
		logic                       error;
		logic [15:0]                sig_word;
		logic                       sig_pending;
		logic                       sig_strobe;
		logic [15:0]                din_word;
		logic                       din_strobe;
		logic [15:0]                dout_low;
		logic [15:0]                dout_high;
		logic                       read_ready;
		logic                       write_ready;
		logic                       err_pending;
	} state_t;

	state_t s_q;
	state_t s_d;

	function automatic logic [15:0] capability_word();
		logic [15:0] w;
		w = 16'h0000;
		w[msg_regs_pkg::CAP_SERVANT_ONLY_BIT]  = SERVANT_ONLY;
		w[msg_regs_pkg::CAP_SIGNAL_ABSENT_BIT] = ~SIGNAL_PRESENT;
		w[msg_regs_pkg::CAP_NO_MASTER_BIT]     = ~MASTER_CAPABLE;
		w[msg_regs_pkg::CAP_INTERRUPTER_BIT]   = INTERRUPTER;
		w[msg_regs_pkg::CAP_FAST_HS_BIT]       = ~FAST_HANDSHAKE;
		w[msg_regs_pkg::CAP_NO_SHMEM_BIT]      = ~SHARED_MEMORY;
		w[msg_regs_pkg::CAP_WIDE32_BIT]        = ~WIDE32;
		w[msg_regs_pkg::CAP_WIDE64_BIT]        = ~(WIDE32 & WIDE64);
		w[7:4] = msg_regs_pkg::RESERVED_ONES_FIELD;
		w[3:0] = DEV_DEP_BITS;
		return w;
	endfunction : capability_word

	// Status word is assembled from independent flops and the live byte ready inputs,
	// so no bit is rewritten when another changes
	function automatic logic [15:0] status_word(input state_t s);
		logic [15:0] w;
		w = 16'h0000;
		w[msg_regs_pkg::HS_ZERO_BIT]      = 1'b0;
		w[msg_regs_pkg::HS_RESERVED_BIT]  = 1'b1;
		w[msg_regs_pkg::HS_BYTE_OUT_BIT]  = byte_out_ready;
		w[msg_regs_pkg::HS_BYTE_IN_BIT]   = byte_in_ready;
		w[msg_regs_pkg::HS_ERR_N_BIT]     = ~s.err_pending;
		w[msg_regs_pkg::HS_READ_RDY_BIT]  = s.read_ready;
		w[msg_regs_pkg::HS_WRITE_RDY_BIT] = s.write_ready;
		w[8]   = 1'b1;
		w[7:0] = {1'b1, STATUS_DEV_BITS};
		return w;
	endfunction : status_word

	// Offset match inside the short window
	function automatic logic window_hit(input logic [5:0] a,
		input logic [5:0] ofs);
		return a == ofs;
	endfunction : window_hit

	// Read value of one window offset; unmapped offsets read all ones
	function automatic logic [15:0] read_word(input logic [5:0] a,
		input state_t s);
		logic [15:0] w;
		w = 16'hFFFF;
		case (a)
			msg_regs_pkg::CAPABILITY_FLAGS_OFS: w = capability_word();
			msg_regs_pkg::HANDSHAKE_STATUS_OFS: w = status_word(s);
			msg_regs_pkg::DATA_HIGH_OFS:        w = s.dout_high;
			msg_regs_pkg::DATA_LOW_OFS:         w = s.dout_low;
			default:                            w = 16'hFFFF;
		endcase
		return w;
	endfunction : read_word

	// Store a signal word and pulse the location monitor
	function automatic state_t accept_signal(input state_t s,
		input logic [15:0] word);
		state_t n;
		n             = s;
		n.sig_word    = word;
		n.sig_pending = 1'b1;
		n.sig_strobe  = 1'b1;
		return n;
	endfunction : accept_signal

	// The take edge and the edge that registers the retry both count,
	// so the retry stands STRETCH_LIMIT - 1 cycles after the take
	function automatic logic stretch_done(input logic [31:0] count);
		return count >= 32'(STRETCH_LIMIT - 2);
	endfunction : stretch_done

	// Terminations follow the next state and drop with the live strobe
	function automatic logic [2:0] term_lines(input state_t s,
		input logic stb);
		logic [2:0] t;
		t = 3'h0;
		if ((s.state == msg_regs_pkg::ST_TERM) && stb) begin
			case (s.term)
				msg_regs_pkg::TERM_ACK:   t = 3'h1;
				msg_regs_pkg::TERM_RETRY: t = 3'h2;
				msg_regs_pkg::TERM_ERROR: t = 3'h4;
				default:                  t = 3'h0;
			endcase
		end
		return t;
	endfunction : term_lines

	logic strobe;
	logic odd_lane;
	logic sig_hit;
	logic low_hit;

	always_comb begin
		strobe   = bus_sel & (bus_ds0 | bus_ds1);
		odd_lane = bus_ds0;  // Low lane holds the odd byte
		sig_hit  = window_hit(bus_addr, msg_regs_pkg::SIGNAL_INBOX_OFS);
		low_hit  = window_hit(bus_addr, msg_regs_pkg::DATA_LOW_OFS);
	end

	always_comb begin
		s_d = s_q;
		s_d.sig_strobe = 1'b0;
		s_d.din_strobe = 1'b0;

		// Set wins over clear for the error, signal and read ready flags
		if (signal_consume) begin
			s_d.sig_pending = 1'b0;
		end
		if (protocol_error_reported) begin
			s_d.err_pending = 1'b0;
		end
		if (protocol_error_set) begin
			s_d.err_pending = 1'b1;
		end
		if (result_load) begin
			s_d.dout_low   = result_low;
			s_d.dout_high  = result_high;
			s_d.read_ready = 1'b1;
		end
		if (write_accept_ready) begin
			s_d.write_ready = 1'b1;
		end

		case (s_q.state)
			msg_regs_pkg::ST_IDLE: begin
				s_d.stretch = 32'h0000_0000;
				if (strobe) begin
					s_d.state = msg_regs_pkg::ST_TERM;
					s_d.term  = msg_regs_pkg::TERM_ACK;
					s_d.rdata = 16'hFFFF;
					if (!bus_write) begin
						s_d.rdata = read_word(bus_addr, s_q);
						// A result loaded in the same cycle wins over the read
						if (low_hit && !result_load) begin
							s_d.read_ready = 1'b0;
						end
					end else if (sig_hit && SIGNAL_PRESENT) begin
						// Byte write on the even lane alone stays unseen
						if (!odd_lane) begin
							s_d.term = msg_regs_pkg::TERM_ACK;
						end else if (s_q.sig_pending && !signal_consume) begin
							s_d.state = msg_regs_pkg::ST_WAIT;
						end else begin
							s_d = accept_signal(s_d, bus_wdata);
						end
					end else if (low_hit) begin
						s_d.din_word    = bus_wdata;
						s_d.din_strobe  = 1'b1;
						s_d.write_ready = 1'b0;
					end else if (sig_hit) begin
						// Non-working signal register: acknowledged, data dropped
						s_d.term = msg_regs_pkg::TERM_ACK;
					end
				end
			end
			msg_regs_pkg::ST_WAIT: begin
				// Stretch while the earlier signal may still be consumed
				if (!strobe) begin
					// Master withdrew: drop the word, never store stale data
					s_d.state = msg_regs_pkg::ST_IDLE;
				end else if (!s_q.sig_pending || signal_consume) begin
					s_d       = accept_signal(s_d, bus_wdata);
					s_d.term  = msg_regs_pkg::TERM_ACK;
					s_d.state = msg_regs_pkg::ST_TERM;
				end else if (stretch_done(s_q.stretch)) begin
					s_d.term  = RETRY_PREFERRED ? msg_regs_pkg::TERM_RETRY
						: msg_regs_pkg::TERM_ERROR;
					s_d.state = msg_regs_pkg::ST_TERM;
				end else begin
					s_d.stretch = s_q.stretch + 32'h0000_0001;
				end
			end
			msg_regs_pkg::ST_TERM: begin
				if (!strobe) begin
					s_d.state = msg_regs_pkg::ST_IDLE;
				end
			end
			default: s_d.state = msg_regs_pkg::ST_IDLE;
		endcase

		{s_d.error, s_d.retry, s_d.ack} = term_lines(s_d, strobe);
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		bus_rdata      = s_q.rdata;
		bus_ack        = s_q.ack;
		bus_retry      = s_q.retry;
		bus_error      = s_q.error;
		signal_word    = s_q.sig_word;
		signal_pending = s_q.sig_pending;
		signal_strobe  = s_q.sig_strobe;
		data_in_word   = s_q.din_word;
		data_in_strobe = s_q.din_strobe;
	end

endmodule : message_device_comm_regs

// file: msg_regs_pkg.sv
// Purpose: Constants shared by the communication register bank
// Assumes: Short address space offsets count in bytes, 16-bit registers
// Notes:   Capability straps are module parameters of the bank
package msg_regs_pkg;

	// Register byte offsets within the short address window
	localparam logic [5:0] CAPABILITY_FLAGS_OFS = 6'h08;
	localparam logic [5:0] HANDSHAKE_STATUS_OFS = 6'h0A;
	localparam logic [5:0] DATA_HIGH_OFS        = 6'h0C;
	localparam logic [5:0] DATA_LOW_OFS         = 6'h0E;
	localparam logic [5:0] SIGNAL_INBOX_OFS     = 6'h10;

	// Capability register field positions
	localparam int CAP_SERVANT_ONLY_BIT = 15;
	localparam int CAP_SIGNAL_ABSENT_BIT = 14;
	localparam int CAP_NO_MASTER_BIT    = 13;
	localparam int CAP_INTERRUPTER_BIT  = 12;
	localparam int CAP_FAST_HS_BIT      = 11;
	localparam int CAP_NO_SHMEM_BIT     = 10;
	localparam int CAP_WIDE32_BIT       = 9;
	localparam int CAP_WIDE64_BIT       = 8;
	localparam logic [3:0] RESERVED_ONES_FIELD = 4'hF;

	// Handshake status field positions
	localparam int HS_ZERO_BIT      = 15;
	localparam int HS_RESERVED_BIT  = 14;
	localparam int HS_BYTE_OUT_BIT  = 13;
	localparam int HS_BYTE_IN_BIT   = 12;
	localparam int HS_ERR_N_BIT     = 11;
	localparam int HS_READ_RDY_BIT  = 10;
	localparam int HS_WRITE_RDY_BIT = 9;

	// Signal word layout
	localparam int SIG_EVENT_BIT = 15;

	// Termination stretch limit
	localparam int CLOCK_HZ         = 25_000_000;
	localparam int STRETCH_LIMIT_US = 20;
	localparam int STRETCH_CYCLES   = (STRETCH_LIMIT_US * (CLOCK_HZ / 1_000_000));

	// Bus cycle states
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_WAIT   = 2'b01,
		ST_TERM   = 2'b10
	} cycle_state_t;

	// Terminations
	typedef enum logic [1:0] {
		TERM_ACK   = 2'b00,
		TERM_RETRY = 2'b01,
		TERM_ERROR = 2'b10
	} term_t;

endpackage : msg_regs_pkg

// file: comm_regs_checker_sva.sv
// Purpose: Port checker for the communication register bank
// Assumes: Default capability straps of the bank
// Notes:   Bound to the bank, sees its ports only
module comm_regs_checker #(
	parameter int STRETCH_LIMIT = 8
) (
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic        bus_sel,
	input wire logic [5:0]  bus_addr,
	input wire logic        bus_write,
	input wire logic        bus_ds0,
	input wire logic        bus_ds1,
	input wire logic [15:0] bus_wdata,
	input wire logic [15:0] bus_rdata,
	input wire logic        bus_ack,
	input wire logic        bus_retry,
	input wire logic        bus_error,
	input wire logic [15:0] signal_word,
	input wire logic        signal_pending,
	input wire logic        signal_strobe,
	input wire logic        signal_consume,
	input wire logic [15:0] data_in_word,
	input wire logic        data_in_strobe,
	input wire logic        byte_out_ready,
	input wire logic        byte_in_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TERM_WAIT = STRETCH_LIMIT + 1;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence take_s;
		bus_sel && (bus_ds0 || bus_ds1) && !$past(bus_sel && (bus_ds0 || bus_ds1));
	endsequence
	sequence sig_wr_s;
		take_s ##0 (bus_write && bus_addr == msg_regs_pkg::SIGNAL_INBOX_OFS);
	endsequence
	AST_CAP_VALUE: assert property ($rose(bus_ack) && !bus_write
		&& bus_addr == msg_regs_pkg::CAPABILITY_FLAGS_OFS |-> bus_rdata == 16'h8FFF)
		else $error("capability word wrong");
	AST_STATUS_FIXED: assert property (take_s ##0 (!bus_write
		&& bus_addr == msg_regs_pkg::HANDSHAKE_STATUS_OFS) |=> bus_ack && bus_rdata[15:12]
		== {2'h1, $past(byte_out_ready), $past(byte_in_ready)}) else $error("status top");
	AST_PLAIN_ACK: assert property (take_s ##0
		(bus_addr != msg_regs_pkg::SIGNAL_INBOX_OFS) |=> bus_ack && !bus_retry && !bus_error)
		else $error("plain access not acked next cycle");
	AST_TERM_HOLD: assert property ((bus_ack || bus_retry) && bus_sel
		&& (bus_ds0 || bus_ds1) |=> $stable({bus_ack, bus_retry, bus_rdata}))
		else $error("termination dropped under strobe");
	AST_SIG_STORE: assert property (sig_wr_s ##0 (bus_ds0 && !signal_pending)
		|=> bus_ack && signal_strobe && signal_pending && signal_word == $past(bus_wdata))
		else $error("free signal write not stored");
	AST_SIG_EVEN: assert property (sig_wr_s ##0 (!bus_ds0 && !signal_pending)
		|=> bus_ack && !signal_strobe && !signal_pending) else $error("even lane stored");
	AST_SIG_STALL: assert property (sig_wr_s ##0 (bus_ds0 && signal_pending
		&& !signal_consume) |=> !bus_ack && !signal_strobe) else $error("overwrite acked");
	AST_SIG_BOUND: assert property (sig_wr_s |-> ##[1:TERM_WAIT]
		(bus_ack || bus_retry || bus_error)) else $error("signal stretch too long");
	AST_LOW_WRITE: assert property (take_s ##0 (bus_write
		&& bus_addr == msg_regs_pkg::DATA_LOW_OFS) |=> data_in_strobe
		&& data_in_word == $past(bus_wdata)) else $error("low data write lost");
endmodule : comm_regs_checker

bind message_device_comm_regs comm_regs_checker #(.STRETCH_LIMIT(STRETCH_LIMIT))
	u_comm_regs_checker (.clock, .sys_rst, .bus_sel, .bus_addr, .bus_write,
	.bus_ds0, .bus_ds1, .bus_wdata, .bus_rdata, .bus_ack, .bus_retry, .bus_error,
	.signal_word, .signal_pending, .signal_strobe, .signal_consume, .data_in_word,
	.data_in_strobe, .byte_out_ready, .byte_in_ready);

// file: commander_model.sv
// Purpose: Commander-side bus master for the short window
// Assumes: Terminations are sampled on rising edges only
// Notes:   Released address and data lines show the inverse of their last value
module commander_model (
	input  wire logic        clock,
	input  wire logic [15:0] bus_rdata,
	input  wire logic        bus_ack,
	input  wire logic        bus_retry,
	input  wire logic        bus_error,
	output logic             bus_sel,
	output logic [5:0]       bus_addr,
	output logic             bus_write,
	output logic             bus_ds0,
	output logic             bus_ds1,
	output logic [15:0]      bus_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {bus_sel, bus_write, bus_ds1, bus_ds0, bus_addr, bus_wdata} = 26'h0;
	task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d,
		input logic [1:0] ln, input int tries, output logic [15:0] rd,
		output logic [2:0] t);
		int n;
		for (int k = 0; k < tries; k++) begin
			@(posedge clock);
			{bus_sel, bus_write, bus_addr, bus_wdata, bus_ds1, bus_ds0} <= {1'h1, w, a, d, ln};
			n = 0;
			do begin
				@(posedge clock);
				n++;
			end while (!(bus_ack || bus_retry || bus_error) && n < 40);
			rd = bus_rdata;
			t = {bus_error, bus_retry, bus_ack};
			{bus_sel, bus_ds1, bus_ds0} <= 3'h0;
			{bus_addr, bus_wdata} <= ~{a, d};
			repeat (2) @(posedge clock);
			if (t[1] == 1'h0) break;
		end
	endtask : xfer
endmodule : commander_model

// file: tb_message_device_comm_regs.sv
// Purpose: Self-checking bench for the communication register bank
// Assumes: Default straps, stretch limit shortened to 8 cycles
// Notes:   Bus cycles go through the commander model
module tb_message_device_comm_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'h0, sys_rst = 1'h1;
	logic        bus_sel, bus_write, bus_ds0, bus_ds1, bus_ack, bus_retry, bus_error;
	logic        signal_pending, signal_strobe, data_in_strobe;
	logic [5:0]  bus_addr;
	logic [15:0] bus_wdata, bus_rdata, signal_word, data_in_word, rd, w;
	logic [2:0]  t;
	logic        signal_consume = 1'h0, result_load = 1'h0, write_accept_ready = 1'h0;
	logic        byte_out_ready = 1'h0, byte_in_ready = 1'h0;
	logic        protocol_error_set = 1'h0, protocol_error_reported = 1'h0;
	logic [15:0] result_low = 16'h0, result_high = 16'h0;
	int          num_errors = 0, compares = 0, seed = 45;
	always #20 clock = ~clock;
	message_device_comm_regs #(.STRETCH_LIMIT(8)) u_message_device_comm_regs (.clock,
		.sys_rst, .bus_sel, .bus_addr, .bus_write, .bus_ds0, .bus_ds1, .bus_wdata,
		.bus_rdata, .bus_ack, .bus_retry, .bus_error, .signal_word, .signal_pending,
		.signal_strobe, .signal_consume, .data_in_word, .data_in_strobe, .result_low,
		.result_high, .result_load, .write_accept_ready, .byte_out_ready,
		.byte_in_ready, .protocol_error_set, .protocol_error_reported);
	commander_model u_commander_model (.clock, .bus_rdata, .bus_ack, .bus_retry,
		.bus_error, .bus_sel, .bus_addr, .bus_write, .bus_ds0, .bus_ds1, .bus_wdata);
	function automatic logic [15:0] hs_exp(input logic err, rr, wr_rdy);
		return {2'h1, byte_out_ready, byte_in_ready, ~err, rr, wr_rdy, 9'h1FF};
	endfunction : hs_exp
	task automatic chk(input string what, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic cyc(input logic wr, input logic [5:0] a, input logic [15:0] d,
		input logic [1:0] ln, input logic [2:0] te);
		u_commander_model.xfer(wr, a, d, ln, 1, rd, t);
		chk("termination", {13'h0, t}, {13'h0, te});
	endtask : cyc
	task automatic hs(input logic err, rr, wr_rdy);
		cyc(1'h0, msg_regs_pkg::HANDSHAKE_STATUS_OFS, 16'h0, 2'h3,
			3'h1);
		chk("status", rd, hs_exp(err, rr, wr_rdy));
	endtask : hs
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (4000) @(posedge clock);
		num_errors++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clock);
		sys_rst <= 1'h0;
		cyc(1'h0, msg_regs_pkg::CAPABILITY_FLAGS_OFS, 16'h0, 2'h3, 3'h1);
		chk("capability", rd, {1'h1, 1'h0, 1'h0, 1'h0, 12'hFFF});
		cyc(1'h0, 6'h20, 16'h0, 2'h3, 3'h1);
		chk("unmapped", rd, 16'hFFFF);
		for (int i = 0; i < 4; i++) begin
			@(posedge clock) {byte_out_ready, byte_in_ready} <= 2'(i);
			hs(1'h0, 1'h0, 1'h0);
		end
		@(posedge clock) protocol_error_set <= 1'h1;
		@(posedge clock) protocol_error_set <= 1'h0;
		hs(1'h1, 1'h0, 1'h0);
		@(posedge clock) protocol_error_reported <= 1'h1;
		@(posedge clock) protocol_error_reported <= 1'h0;
		hs(1'h0, 1'h0, 1'h0);
		$display("status tests done");
		w = 16'($random(seed));
		@(posedge clock) {result_low, result_high, result_load} <= {w, ~w, 1'h1};
		@(posedge clock) result_load <= 1'h0;
		hs(1'h0, 1'h1, 1'h0);
		cyc(1'h0, msg_regs_pkg::DATA_HIGH_OFS, 16'h0, 2'h3, 3'h1);
		chk("data high", rd, ~w);
		cyc(1'h0, msg_regs_pkg::DATA_LOW_OFS, 16'h0, 2'h3, 3'h1);
		chk("data low", rd, w);
		hs(1'h0, 1'h0, 1'h0);
		@(posedge clock) write_accept_ready <= 1'h1;
		@(posedge clock) write_accept_ready <= 1'h0;
		hs(1'h0, 1'h0, 1'h1);
		cyc(1'h1, msg_regs_pkg::DATA_LOW_OFS, ~w, 2'h3, 3'h1);
		chk("data in", data_in_word, ~w);
		hs(1'h0, 1'h0, 1'h0);
		$display("data register tests done");
		w = {1'h1, 7'($random(seed)), 8'h2A};
		cyc(1'h1, msg_regs_pkg::SIGNAL_INBOX_OFS, w, 2'h3, 3'h1);
		chk("signal word", signal_word, w);
		chk("pending", {15'h0, signal_pending}, 16'h1);
		cyc(1'h1, msg_regs_pkg::SIGNAL_INBOX_OFS, ~w, 2'h3, 3'h2);
		chk("kept word", signal_word, w);
		@(posedge clock) signal_consume <= 1'h1;
		@(posedge clock) signal_consume <= 1'h0;
		@(posedge clock) chk("consumed", {15'h0, signal_pending}, 16'h0);
		cyc(1'h1, msg_regs_pkg::SIGNAL_INBOX_OFS, ~w, 2'h2, 3'h1);
		chk("even lane", signal_word, w);
		w = {1'h0, 7'($random(seed)), 8'h2A};
		cyc(1'h1, msg_regs_pkg::SIGNAL_INBOX_OFS, w, 2'h3, 3'h1);
		fork
			cyc(1'h1, msg_regs_pkg::SIGNAL_INBOX_OFS, ~w, 2'h3, 3'h1);
			begin
				repeat (3) @(posedge clock);
				signal_consume <= 1'h1;
				@(posedge clock) signal_consume <= 1'h0;
			end
		join
		chk("stretched word", signal_word, ~w);
		$display("signal tests done");
		end_of_test();
	end
endmodule : tb_message_device_comm_regs
